// ==== opt_supervisor.sv ====
`timescale 1ns/10ps
// How it works
// - Rail B zero load-line overshoot tri-states phases
// - Load-line compensation overshoot tri-states phases
// - Suppression turns off both switches
// - Single phase deviation issues early pulse
// - Register bit enables auto phase management
// - Phase count follows summed current thresholds
// - Phase added at once above threshold
// - Drop below threshold minus hysteresis, delayed
// - Below zero current enter diode emulation
// - Rise, fall without decay, fast response, force bit: all phases
// - Averaged 10-bit voltage report, high/low registers
// - Current code mapped onto selected full scale
// - Gain and offset trim on current
// - Averaged 10-bit current report, two registers
// - Temperature updated each 700 us, 5.6 ms
// - Undervoltage shuts down, phases tri-stated
// - Soft-start overcurrent trips, alerts, sets bit
// - Soft-start limit is scale times (ratio+1)/8
// - Fault sticks until power or enable toggles
module opt_supervisor #(
   parameter int NPH            = 8,                          // Phases on this rail
   parameter bit RAIL_B         = 1'b0,                       // Rail with absolute mode
   parameter int AVG_K          = 3,                          // Log2 report window
   parameter int TEMP_TICK_CYC  = opt_pkg::TEMP_UPDATE_CYC,   // Temperature period
   parameter int DROP_DELAY_CYC = opt_pkg::DROP_DELAY_CYC     // Phase drop delay
) (
   input  wire logic             i_clk_sys,
   input  wire logic             i_rst,
   input  wire opt_pkg::opt_cfg_t   i_cfg,
   input  wire opt_pkg::opt_sense_t i_sense,
   input  wire logic [7:0]       i_reg_addr,
   input  wire logic             i_reg_wr,
   input  wire logic [7:0]       i_reg_wdata,
   output logic      [7:0]       o_reg_rdata,
   output logic      [NPH-1:0]   o_phase_on,
   output logic                  o_phase_tristate,
   output logic                  o_early_pulse,
   output logic                  o_diode_emulation,
   output logic                  o_rail_run,
   output logic                  o_overcurrent_alert_pin_o,
   output logic                  o_overcurrent_alert_pin_oe
);

   localparam int NW = $clog2(NPH + 1);  // Phase count width

   // All state of the block
   typedef struct packed {
      logic [1:0]             phase_ctrl;  // Auto enable and force bits
      opt_pkg::opt_ovs_state_t ovs;        // Overshoot guard state
      logic [NW-1:0]          nph;         // Phases chosen by the manager
      logic [15:0]            drop_cnt;    // Phase drop delay counter
      logic [15:0]            temp_cnt;    // Temperature update timer
      logic [7:0]             ss_cnt;      // Soft-start window timer
      logic                   ss_fault;    // Sticky soft-start fault
      logic                   pwr_en;      // Last enable level
      logic                   early;       // Early pulse request
      logic [7:0]             rdata;       // Read data
   } opt_state_t;

   opt_state_t q;  // Registered state
   opt_state_t d;  // Next state

   logic          zero_ll;       // Absolute mode in effect
   logic          abs_trip;      // Absolute overshoot above threshold
   logic          ll_trip;       // Compensation excursion above threshold
   logic          ovs_trip;      // Overshoot guard entry
   logic          auto_en;       // Auto phase management on
   logic          full_req;      // Any reason but auto off to run every phase
   logic [NW-1:0] eff_nph;       // Phases actually running
   logic [NPH-1:0] phase_mask;   // Phases enabled before tri-state
   logic [17:0]   gain_prod;     // Current times gain trim
   logic [12:0]   trim_sum;      // Trimmed current, signed
   logic [9:0]    cur_trim;      // Trimmed current, clamped
   logic [9:0]    vout_rpt;      // Averaged voltage
   logic [9:0]    iout_rpt;      // Averaged current
   logic [7:0]    temperature_report;      // Averaged temperature
   logic [15:0]   add_lvl;       // Current that needs another phase
   logic [15:0]   drop_lvl;      // Current level of the present count
   logic          add_ok;        // Add a phase now
   logic          drop_ok;       // Current low enough to drop
   logic          temp_tick;     // Temperature sample moment
   logic [10:0]   ss_limit;      // Soft-start current limit code
   logic          ss_trip;       // Soft-start overcurrent seen
   logic          pwr_fall;      // Enable toggled off

   // Overshoot detection; absolute mode only on rail B in zero load-line
   assign zero_ll  = RAIL_B & i_cfg.zero_loadline;
   assign abs_trip = i_sense.ovs_magnitude[7:5] > i_cfg.absolute_overshoot_guard_th;
   assign ll_trip  = i_sense.comp_deviation[7:5] > i_cfg.loadline_ovs_th;
   assign ovs_trip = zero_ll ? abs_trip : ll_trip;

   // Phase force sources
   assign auto_en  = q.phase_ctrl[opt_pkg::BIT_AUTO_PHASE];
   assign full_req = i_sense.voltage_transition_rise
                   | (i_sense.voltage_transition_fall & ~i_sense.decay_mode)
                   | i_sense.fast_response
                   | q.phase_ctrl[opt_pkg::BIT_FORCE_FULL];
   assign eff_nph  = (full_req | ~auto_en) ? NW'(NPH) : q.nph;

   // Thermometer mask of the running phases
   always_comb begin
      for (int i = 0; i < NPH; i++) begin
         phase_mask[i] = (NW'(i) < eff_nph);
      end
   end

   // Current trim: gain of 128 is unity, offset is signed codes
   assign gain_prod = 18'(i_sense.current_code) * 18'(i_cfg.gain_trim);
   assign trim_sum  = 13'(gain_prod[17:opt_pkg::GAIN_SHIFT])
                    + {{5{i_cfg.offset_trim[7]}}, i_cfg.offset_trim};

   // Clamp to the 10-bit code range of the selected full scale
   always_comb begin
      if (trim_sum[12]) begin
         cur_trim = 10'h000;
      end else if (trim_sum[11:10] != 2'b00) begin
         cur_trim = 10'h3FF;
      end else begin
         cur_trim = trim_sum[9:0];
      end
   end

   // Phase thresholds scale with the present count
   assign add_lvl  = 16'(q.nph) * 16'(i_cfg.phase_count_th);
   assign drop_lvl = 16'(q.nph - 1'b1) * 16'(i_cfg.phase_count_th);
   assign add_ok   = (16'(cur_trim) > add_lvl) && (q.nph < NW'(NPH));
   assign drop_ok  = (16'(cur_trim) + 16'(i_cfg.phase_drop_hys) < drop_lvl)
                   && (q.nph > NW'(1));

   // Temperature sample timer
   assign temp_tick = (q.temp_cnt == 16'(TEMP_TICK_CYC - 1));

   // Soft-start limit is (ratio+1)/8 of full scale
   assign ss_limit = {4'(i_cfg.softstart_ratio + 3'h1), 7'h00};
   assign ss_trip  = i_sense.softstart
                   && (q.ss_cnt < 8'(opt_pkg::SS_WINDOW_CYC))
                   && (11'(i_sense.current_code) > ss_limit);
   assign pwr_fall = q.pwr_en & ~i_sense.power_enable;

   // Next-state logic
   always_comb begin
      d = q;
      d.pwr_en = i_sense.power_enable;

      // Host write to the phase control register
      if (i_reg_wr && (i_reg_addr == opt_pkg::ADDR_PHASE_CTRL)) begin
         d.phase_ctrl = i_reg_wdata[1:0];
      end

      // Overshoot guard holds phases off until current or voltage settles
      case (q.ovs)
         opt_pkg::OVS_IDLE: begin
            if (ovs_trip) begin
               d.ovs = opt_pkg::OVS_CLAMP;
            end
         end
         opt_pkg::OVS_CLAMP: begin
            if (i_sense.zero_current || i_sense.voltage_sense_input_normal) begin
               d.ovs = opt_pkg::OVS_IDLE;
            end
         end
         default: begin
            d.ovs = opt_pkg::OVS_IDLE;
         end
      endcase

      // Phase manager
      if (full_req || !auto_en) begin
         d.nph      = NW'(NPH);
         d.drop_cnt = 16'h0000;
      end else if (add_ok) begin
         d.nph      = q.nph + 1'b1;
         d.drop_cnt = 16'h0000;
      end else if (drop_ok) begin
         if (q.drop_cnt == 16'(DROP_DELAY_CYC - 1)) begin
            d.nph      = q.nph - 1'b1;
            d.drop_cnt = 16'h0000;
         end else begin
            d.drop_cnt = q.drop_cnt + 16'h0001;
         end
      end else begin
         d.drop_cnt = 16'h0000;
      end

      // Early pulse in single phase on large compensation deviation
      d.early = (eff_nph == NW'(1))
              && (i_sense.comp_deviation[7:5] > i_cfg.early_pulse_th);

      // Temperature timer
      d.temp_cnt = temp_tick ? 16'h0000 : q.temp_cnt + 16'h0001;

      // Soft-start window runs from the start of the ramp
      if (!i_sense.softstart) begin
         d.ss_cnt = 8'h00;
      end else if (q.ss_cnt != 8'hFF) begin
         d.ss_cnt = q.ss_cnt + 8'h01;
      end

      // Sticky fault: set wins over the enable toggle that clears it
      if (ss_trip) begin
         d.ss_fault = 1'b1;
      end else if (pwr_fall) begin
         d.ss_fault = 1'b0;
      end

      // Registered read data
      case (i_reg_addr)
         opt_pkg::ADDR_PHASE_CTRL: d.rdata = {6'h00, q.phase_ctrl};
         opt_pkg::ADDR_FAULT:      d.rdata = {1'b0, q.ss_fault, 6'h00};
         opt_pkg::ADDR_TEMP:       d.rdata = temperature_report;
         opt_pkg::ADDR_VOUT_L:     d.rdata = vout_rpt[7:0];
         opt_pkg::ADDR_VOUT_H:     d.rdata = {6'h00, vout_rpt[9:8]};
         opt_pkg::ADDR_IOUT_L:     d.rdata = iout_rpt[7:0];
         opt_pkg::ADDR_IOUT_H:     d.rdata = {6'h00, iout_rpt[9:8]};
         opt_pkg::ADDR_STATUS:     d.rdata = {q.ovs == opt_pkg::OVS_CLAMP,
                                              i_sense.zero_current, q.early,
                                              full_req, 4'(eff_nph)};
         default:                  d.rdata = 8'h00;
      endcase
   end

   // State register
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         q            <= '0;
         q.phase_ctrl <= opt_pkg::PHASE_CTRL_RST[1:0];
         q.nph        <= NW'(NPH);
      end else begin
         q <= d;
      end
   end

   // Report averagers
   opt_avg #(.W(10), .K(AVG_K)) u_vout_avg (
      .i_clk_sys (i_clk_sys),
      .i_rst     (i_rst),
      .i_valid   (i_sense.vout_valid),
      .i_sample  (i_sense.vout_code),
      .o_mean    (vout_rpt)
   );

   opt_avg #(.W(10), .K(AVG_K)) u_iout_avg (
      .i_clk_sys (i_clk_sys),
      .i_rst     (i_rst),
      .i_valid   (i_sense.current_valid),
      .i_sample  (cur_trim),
      .o_mean    (iout_rpt)
   );

   opt_avg #(.W(8), .K($clog2(opt_pkg::TEMP_AVG_DEPTH))) u_temp_avg (
      .i_clk_sys (i_clk_sys),
      .i_rst     (i_rst),
      .i_valid   (temp_tick),
      .i_sample  (i_sense.temp_code),
      .o_mean    (temperature_report)
   );

   // Both switches off: any tri-state cause parks every phase
   assign o_rail_run       = i_sense.power_enable & ~i_sense.undervoltage
                           & ~q.ss_fault;
   assign o_phase_tristate = i_sense.undervoltage | q.ss_fault
                           | (q.ovs == opt_pkg::OVS_CLAMP) | ~o_rail_run;
   assign o_phase_on       = o_phase_tristate ? '0 : phase_mask;
   assign o_early_pulse    = q.early & ~o_phase_tristate;
   assign o_diode_emulation = i_sense.zero_current;
   assign o_reg_rdata      = q.rdata;

   // Open-drain alert pulls low while the fault stands
   assign o_overcurrent_alert_pin_o  = 1'b0;
   assign o_overcurrent_alert_pin_oe = q.ss_fault;

   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);

   abs_entry_a: assert property (zero_ll && q.ovs == opt_pkg::OVS_IDLE && abs_trip
      |=> q.ovs == opt_pkg::OVS_CLAMP && o_phase_tristate)
      else $error("absolute overshoot did not tri-state");
   ll_entry_a: assert property (!zero_ll && q.ovs == opt_pkg::OVS_IDLE && ll_trip
      |=> o_phase_tristate && o_phase_on == '0)
      else $error("load-line overshoot did not tri-state");
   hiz_both_a: assert property (q.ovs == opt_pkg::OVS_CLAMP |-> o_phase_on == '0)
      else $error("phase driven during overshoot clamp");
   early_pulse_a: assert property (eff_nph == NW'(1) && !o_phase_tristate
      && i_sense.comp_deviation[7:5] > i_cfg.early_pulse_th ##1 !o_phase_tristate
      |-> o_early_pulse)
      else $error("early pulse missing");
   add_now_a: assert property (auto_en && !full_req && add_ok
      |=> q.nph == $past(q.nph) + 1'b1)
      else $error("phase not added at once");
   drop_step_a: assert property (q.nph < $past(q.nph) && !$past(i_rst)
      |-> q.nph == $past(q.nph) - 1'b1 && q.nph >= NW'(1))
      else $error("phase drop skipped a step");
   force_full_a: assert property (full_req |-> phase_mask == {NPH{1'b1}})
      else $error("full phase not forced");
   supply_undervoltage_lockout_off_a: assert property (i_sense.undervoltage
      |-> o_phase_tristate && o_phase_on == '0 && !o_rail_run)
      else $error("undervoltage left phases on");
   ss_trip_a: assert property (ss_trip
      |=> q.ss_fault && o_overcurrent_alert_pin_oe && o_phase_tristate)
      else $error("soft-start overcurrent not flagged");
   ss_hold_a: assert property (q.ss_fault && !pwr_fall |=> q.ss_fault)
      else $error("fault cleared without enable toggle");

endmodule

// ==== opt_pkg.sv ====
package opt_pkg;

   // Register offsets on the I2C register port
   localparam logic [7:0] ADDR_PHASE_CTRL = 8'h12;  // Phase force control, RW
   localparam logic [7:0] ADDR_FAULT      = 8'h1A;  // Fault status, RO
   localparam logic [7:0] ADDR_TEMP       = 8'h23;  // Filtered temperature, RO
   localparam logic [7:0] ADDR_VOUT_L     = 8'h24;  // Output voltage report low
   localparam logic [7:0] ADDR_VOUT_H     = 8'h25;  // Output voltage report high
   localparam logic [7:0] ADDR_IOUT_L     = 8'h26;  // Current report low
   localparam logic [7:0] ADDR_IOUT_H     = 8'h27;  // Current report high
   localparam logic [7:0] ADDR_STATUS     = 8'h28;  // Live supervision status

   // Field positions
   localparam int BIT_FORCE_FULL = 0;  // Force all phases on
   localparam int BIT_AUTO_PHASE = 1;  // Automatic phase management enable
   localparam int BIT_SS_FAULT   = 6;  // Soft-start overcurrent fault

   // Values after reset
   localparam logic [7:0] PHASE_CTRL_RST = 8'h02;  // Auto phase on, force off

   // Timing
   localparam int CLK_PERIOD_NS   = 40;              // 25 MHz system clock
   localparam int TEMP_UPDATE_US  = 700;             // Temperature update period
   localparam int TEMP_WINDOW_US  = 5600;            // Temperature averaging window
   localparam int TEMP_UPDATE_CYC = TEMP_UPDATE_US * 1000 / CLK_PERIOD_NS;
   localparam int TEMP_AVG_DEPTH  = TEMP_WINDOW_US / TEMP_UPDATE_US;
   localparam int SS_WINDOW_NS    = 5000;            // Soft-start detect window
   localparam int SS_WINDOW_CYC   = SS_WINDOW_NS / CLK_PERIOD_NS;
   localparam int DROP_DELAY_US   = 10;              // Phase drop delay
   localparam int DROP_DELAY_CYC  = (DROP_DELAY_US * 1000 + CLK_PERIOD_NS - 1)
                                    / CLK_PERIOD_NS;
   localparam int GAIN_SHIFT      = 7;               // Gain trim of 128 is unity

   // Overshoot suppression states
   typedef enum logic {
      OVS_IDLE,
      OVS_CLAMP
   } opt_ovs_state_t;

   // Stored configuration of one rail
   typedef struct packed {
      logic       zero_loadline;    // Zero load-line operation
      logic [2:0] absolute_overshoot_guard_th;       // Absolute overshoot guard threshold
      logic [2:0] loadline_ovs_th;  // Load-line overshoot guard threshold
      logic [2:0] early_pulse_th;   // Early pulse threshold
      logic [2:0] softstart_ratio;  // Soft-start limit ratio
      logic [7:0] gain_trim;        // Current gain trim
      logic [7:0] offset_trim;      // Current offset trim, two's complement
      logic [7:0] phase_count_th;   // Current per added phase
      logic [7:0] phase_drop_hys;   // Hysteresis below the drop level
   } opt_cfg_t;

   // Sensed analog state, already digitised
   typedef struct packed {
      logic [9:0] vout_code;        // Differential output voltage sample
      logic       vout_valid;       // Voltage sample strobe
      logic [9:0] current_code;     // Summed current minus reference
      logic       current_valid;    // Current sample strobe
      logic [7:0] temp_code;        // Temperature sample
      logic [7:0] ovs_magnitude;    // Absolute overshoot above target
      logic [7:0] comp_deviation;   // Compensation signal excursion
      logic       zero_current;     // Zero-current detector
      logic       voltage_sense_input_normal;      // Sensed voltage back in range
      logic       voltage_transition_rise;        // Positive voltage transition
      logic       voltage_transition_fall;        // Negative voltage transition
      logic       decay_mode;       // Negative transition uses decay
      logic       fast_response;    // A quick-response function fired
      logic       undervoltage;     // Supply undervoltage lockout
      logic       power_enable;     // Rail enable input
      logic       softstart;        // Rail ramping up from zero
   } opt_sense_t;

endpackage

// ==== opt_avg.sv ====
`timescale 1ns/10ps
// Sliding-window mean of the last 2**K samples
module opt_avg #(
   parameter int W = 10,  // Sample width
   parameter int K = 3    // Log2 of window depth
) (
   input  wire logic         i_clk_sys,
   input  wire logic         i_rst,
   input  wire logic         i_valid,
   input  wire logic [W-1:0] i_sample,
   output logic      [W-1:0] o_mean
);

   localparam int DEPTH = 1 << K;

   // Window, running sum and write pointer
   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] win;
      logic [W+K-1:0]          sum;
      logic [K-1:0]            ptr;
   } opt_avg_state_t;

   opt_avg_state_t q;  // Registered state
   opt_avg_state_t d;  // Next state

   // Replace the oldest sample and keep the sum exact
   always_comb begin
      d = q;
      if (i_valid) begin
         d.sum = q.sum + (W+K)'(i_sample) - (W+K)'(q.win[q.ptr]);
         d.win[q.ptr] = i_sample;
         d.ptr = q.ptr + 1'b1;
      end
   end

   // State register
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // Mean comes straight from the sum flops
   assign o_mean = q.sum[W+K-1:K];

endmodule

// ==== opt_stage_model.sv ====
`timescale 1ns/10ps
// Power stage seen by the supervisor: gate drives per phase and the alert wire
module opt_stage_model #(
   parameter int NPH = 8  // Phases driven
) (
   input  wire logic [NPH-1:0] i_phase_on,
   input  wire logic           i_phase_tristate,
   input  wire logic           i_alert_o,
   input  wire logic           i_alert_oe,
   output logic      [NPH-1:0] o_high_side_on,
   output logic      [NPH-1:0] o_low_side_on,
   output logic                o_alert_pin_n
);
   // Tri-state turns both switches off, so current runs in the body diode
   always_comb begin
      o_high_side_on = i_phase_tristate ? '0 : i_phase_on;
      o_low_side_on  = i_phase_tristate ? '0 : i_phase_on;
   end

   // Open-drain wire: pull-up unless the supervisor pulls low
   assign o_alert_pin_n = (i_alert_oe === 1'b1) ? i_alert_o : 1'b1;
endmodule

// ==== tb_top.sv ====
`timescale 1ns/10ps
// Self-checking bench of the supervisor on the absolute-mode rail
module tb_top;
   logic                 clk_sys;     // 25 MHz clock
   logic                 rst;         // Synchronous reset
   opt_pkg::opt_cfg_t    cfg;         // Static rail setup
   opt_pkg::opt_sense_t  sense;       // Sensed state
   logic [7:0]           reg_addr;    // Register address
   logic                 reg_wr;      // Write strobe
   logic [7:0]           reg_wdata;   // Write data
   logic [7:0]           reg_rdata;   // Read data
   logic [7:0]           phase_on;    // Phase enables
   logic                 tristate;    // All phases hi-z
   logic                 early;       // Early pulse
   logic                 diode_emulation;         // Diode emulation
   logic                 rail_run;    // Rail running
   logic                 alert_o;     // Alert drive value
   logic                 alert_oe;    // Alert drive enable
   logic                 alert_n;     // Alert wire level
   int                   err_total;   // Mismatches
   int                   n_checks;    // Comparisons
   // Row of the table: overshoot inputs beside the expected outputs
   typedef struct packed {
      logic zl; logic [7:0] mag; logic [7:0] comp; logic zc; logic uv;
      logic tri_x; logic ep_x; logic dem_x;
   } opt_row_t;
   opt_row_t rows [6];

   // Clock
   always #20 clk_sys = ~clk_sys;

   opt_supervisor #(.RAIL_B(1'b1), .TEMP_TICK_CYC(20), .DROP_DELAY_CYC(4)) i_dut (
      .i_clk_sys(clk_sys), .i_rst(rst), .i_cfg(cfg), .i_sense(sense),
      .i_reg_addr(reg_addr), .i_reg_wr(reg_wr), .i_reg_wdata(reg_wdata),
      .o_reg_rdata(reg_rdata), .o_phase_on(phase_on), .o_phase_tristate(tristate),
      .o_early_pulse(early), .o_diode_emulation(diode_emulation), .o_rail_run(rail_run),
      .o_overcurrent_alert_pin_o(alert_o), .o_overcurrent_alert_pin_oe(alert_oe));

   opt_stage_model #(.NPH(8)) i_stage (
      .i_phase_on(phase_on), .i_phase_tristate(tristate), .i_alert_o(alert_o),
      .i_alert_oe(alert_oe), .o_high_side_on(), .o_low_side_on(), .o_alert_pin_n(alert_n));

   // Compare one value and count it
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   // Register write, one strobe cycle
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask

   // Register read, data one cycle after the address is taken
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk_sys);
      reg_addr <= a;
      @(posedge clk_sys);
      @(posedge clk_sys);
      #1 chk(reg_rdata, exp, "read");
   endtask

   // Wait a number of edges, then settle
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask

   // Verdict
   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   // Watchdog well past the expected run length
   initial begin
      #400000;
      err_total++;
      $display("[FAIL] %0t watchdog expired", $time);
      end_sim();
   end

   // Main sequence
   initial begin
      clk_sys = 0; rst <= 1; reg_addr <= 8'h00; reg_wr <= 0; reg_wdata <= 8'h00;
      err_total = 0; n_checks = 0;
      cfg <= '0; cfg.absolute_overshoot_guard_th <= 3'h3; cfg.loadline_ovs_th <= 3'h4;
      cfg.early_pulse_th <= 3'h3; cfg.softstart_ratio <= 3'h1; cfg.gain_trim <= 8'h80;
      cfg.phase_count_th <= 8'h10; cfg.phase_drop_hys <= 8'h04;
      sense <= '0; sense.power_enable <= 1'b1;
      rows[0] = '{1, 8'h80, 8'h00, 0, 0, 1, 0, 0};
      rows[1] = '{1, 8'h60, 8'h00, 0, 0, 0, 0, 0};
      rows[2] = '{0, 8'h00, 8'hA0, 0, 0, 1, 0, 0};
      rows[3] = '{0, 8'h00, 8'h80, 0, 0, 0, 1, 0};
      rows[4] = '{0, 8'h00, 8'h00, 0, 1, 1, 0, 0};
      rows[5] = '{0, 8'h00, 8'h00, 1, 0, 0, 0, 1};
      repeat (8) @(posedge clk_sys);
      rst <= 1'b0;
      // Reset values, unmapped read
      rd(opt_pkg::ADDR_PHASE_CTRL, opt_pkg::PHASE_CTRL_RST);
      rd(opt_pkg::ADDR_FAULT, 8'h00);
      rd(8'h40, 8'h00);
      // Idle current sheds phases one by one down to one
      cyc(60);
      chk(phase_on, 8'h01, "min phase");
      $display("test reset done");
      // Table of overshoot, lockout and light-load rows
      foreach (rows[i]) begin
         @(posedge clk_sys);
         sense.ovs_magnitude <= rows[i].mag;
         sense.comp_deviation <= rows[i].comp; sense.zero_current <= rows[i].zc;
         sense.undervoltage <= rows[i].uv;
         cfg.zero_loadline <= rows[i].zl;
         cyc(3);
         chk({7'h00, tristate}, {7'h00, rows[i].tri_x}, "tristate");
         chk({7'h00, early}, {7'h00, rows[i].ep_x}, "early");
         chk({7'h00, diode_emulation}, {7'h00, rows[i].dem_x}, "dem");
         if (rows[i].tri_x) chk(phase_on, 8'h00, "off");
         @(posedge clk_sys);
         sense.ovs_magnitude <= 8'h00; sense.comp_deviation <= 8'h00;
         sense.undervoltage <= 1'b0; sense.zero_current <= 1'b1;
         cyc(2);
         chk({7'h00, tristate}, 8'h00, "release");
         sense.zero_current <= 1'b0;
      end
      $display("test table done");
      // Summed current above one threshold adds exactly one phase
      @(posedge clk_sys);
      sense.current_code <= 10'h018; sense.current_valid <= 1'b1;
      cyc(20);
      chk(phase_on, 8'h03, "two phases");
      rd(opt_pkg::ADDR_IOUT_L, 8'h18);
      rd(opt_pkg::ADDR_IOUT_H, 8'h00);
      // Force bit gives all phases and reads back
      wr(opt_pkg::ADDR_PHASE_CTRL, 8'h03);
      #1 chk(phase_on, 8'hFF, "forced");
      rd(opt_pkg::ADDR_PHASE_CTRL, 8'h03);
      wr(opt_pkg::ADDR_PHASE_CTRL, 8'h02);
      // Forced count sheds back to two before the transition cases
      cyc(40);
      chk(phase_on, 8'h03, "shed back");
      // Fall with decay keeps the count; rise, plain fall, fast response force all
      for (int k = 0; k < 4; k++) begin
         @(posedge clk_sys);
         sense.voltage_transition_fall <= (k == 0 || k == 2);
         sense.decay_mode <= (k == 0);
         sense.voltage_transition_rise <= (k == 1);
         sense.fast_response <= (k == 3);
         cyc(1);
         chk(phase_on, (k == 0) ? 8'h03 : 8'hFF, "force source");
      end
      @(posedge clk_sys);
      sense.voltage_transition_fall <= 1'b0;
      sense.decay_mode <= 1'b0;
      sense.voltage_transition_rise <= 1'b0;
      sense.fast_response <= 1'b0;
      $display("test phases done");
      // Voltage report, write to a read-only place is ignored
      sense.vout_code <= 10'h2A5; sense.vout_valid <= 1'b1;
      cyc(12);
      wr(opt_pkg::ADDR_VOUT_L, 8'h00);
      rd(opt_pkg::ADDR_VOUT_L, 8'hA5);
      rd(opt_pkg::ADDR_VOUT_H, 8'h02);
      // Temperature window fills after eight update ticks
      sense.temp_code <= 8'h5A;
      cyc(220);
      rd(opt_pkg::ADDR_TEMP, 8'h5A);
      $display("test telemetry done");
      // Soft-start overcurrent inside the window trips and sticks
      @(posedge clk_sys);
      sense.softstart <= 1'b1; sense.current_code <= 10'h120;
      cyc(3);
      chk({alert_oe, alert_n, rail_run, tristate}, 8'h09, "ss trip");
      @(posedge clk_sys);
      sense.softstart <= 1'b0; sense.current_code <= 10'h000;
      rd(opt_pkg::ADDR_FAULT, 8'h40);
      // Enable toggle by the host side clears the fault
      @(posedge clk_sys);
      sense.power_enable <= 1'b0;
      @(posedge clk_sys);
      sense.power_enable <= 1'b1;
      rd(opt_pkg::ADDR_FAULT, 8'h00);
      chk({alert_oe, rail_run}, 8'h01, "cleared");
      // Overcurrent after the window does not trip
      @(posedge clk_sys);
      sense.softstart <= 1'b1;
      cyc(130);
      sense.current_code <= 10'h120;
      cyc(3);
      chk({7'h00, alert_oe}, 8'h00, "late");
      $display("test softstart done");
      // Mid-run reset puts the control register back to its reset value
      wr(opt_pkg::ADDR_PHASE_CTRL, 8'h01);
      rd(opt_pkg::ADDR_PHASE_CTRL, 8'h01);
      @(posedge clk_sys);
      rst <= 1'b1;
      sense.softstart <= 1'b0;
      @(posedge clk_sys);
      rst <= 1'b0;
      rd(opt_pkg::ADDR_PHASE_CTRL, opt_pkg::PHASE_CTRL_RST);
      $display("test reset again done");
      end_sim();
   end
endmodule
